// ---- hdl/ngp_gpio.v ----
// Contract
// [R1] Read-only register shows input-only pin levels
// [R2] Output-only pins driven from resettable latch
// [R3] Pins take written value after the write
// [R4] Port reads capture value at read acceptance
// [R5] Software treats shared config as write-only
// [R6] Config bit 2 selects pull-up or pull-down
// [R7] Config bit 1 selects push-pull or open-drain
// [R8] Config bit 0 selects resistor or high-Z
// [R9] Sample combined level on 64 Hz falling edge
// [R10] Flag set within one 64 Hz period
// [R11] Level change of combined port sets flag
// [R12] Pull-down mode: change of OR of pins
// [R13] Pull-up mode: change of AND of pins
// [R14] External interrupt 1 vectors to 032H
// [R15] Each bidir pin individually configurable
// [R16] Direction bit one drives pin from latch
// [R17] Bidir read mixes latch and pin per bit
// [R18] Bidir latches at their indices, read/write
// [R19] Reset clears all bidir latches
// [R20] Control holds irq enable, clock, dir, type
// [R21] Compare sample with previous; differ sets flag
`include "ngp_regs.vh"

module ngp_gpio (
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tb_64hz,
  input wire [3:0] in_only_pin,
  output reg in_only_term_en,
  output reg pull_polarity_select,
  output reg [3:0] out_only_data,
  output reg [3:0] out_only_oe_n,
  input wire [11:0] bidir_pin_in,
  output reg [11:0] bidir_pin_out,
  output reg [11:0] bidir_pin_oe_n,
  output reg [11:0] bidir_pull_en,
  output reg [11:0] pin_irq_enable_bit,
  output reg [11:0] pin_irq_sample_clock_bit,
  output reg ext1_request_flag,
  output reg [11:0] ext1_vector
);

  // ============================================================
  // Pin synchronisers
  // Two stages before any logic reads a pin
  // Time base input is already on this clock, so it skips them
  reg [3:0] in_meta;
  reg [3:0] in_sync;
  reg [11:0] bidir_meta;
  reg [11:0] bidir_sync;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
      bidir_meta <= 12'h000;
      bidir_sync <= 12'h000;
    end else begin
      in_meta <= in_only_pin;
      in_sync <= in_meta;
      bidir_meta <= bidir_pin_in;
      bidir_sync <= bidir_meta;
    end
  end

  // ============================================================
  // Register storage
  reg [3:0] output_only_port_latch;
  reg [3:0] bidir_port_a_latch;
  reg [3:0] bidir_port_b_latch;
  reg [3:0] bidir_port_c_latch;
  reg [3:0] shared_port_config;
  reg [47:0] pin_ctrl;
  wire [11:0] bidir_latch_all;
  wire [11:0] dir_bits;
  wire [11:0] type_bits;

  assign bidir_latch_all = {bidir_port_c_latch, bidir_port_b_latch, bidir_port_a_latch};

  // ============================================================
  // AXI4-Lite write channel
  // Address and data are taken in either order and held
  // Response rises the cycle after both halves are held
  // Ready stays low until the response has been taken
  // One write at a time keeps the decode simple
  reg aw_held;
  reg w_held;
  reg [5:0] aw_idx;
  reg [3:0] w_data;
  reg w_lane0;
  wire do_write;
  wire wr_en;
  reg wr_hit;

  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign wr_en = do_write & w_lane0;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 4'h0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NGP_RESP_OKAY;
    end else begin
      if (s_axi_awready & s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end else if (~aw_held & ~s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready & s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[3:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (~w_held & ~s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `NGP_RESP_OKAY : `NGP_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write decode for the 12 pin control registers
  // Slot order: port A pins 0 to 3, then port B, then port C
  wire [5:0] ctrl_sel;
  wire ctrl_range;
  wire [15:0] ctrl_onehot;

  assign ctrl_sel = aw_idx - `NGP_IDX_CTRL0;
  assign ctrl_range = (aw_idx >= `NGP_IDX_CTRL0) &&
                      (aw_idx < (`NGP_IDX_CTRL0 + `NGP_CTRL_COUNT));
  assign ctrl_onehot = 16'h0001 << ctrl_sel[3:0];

  always @* begin
    case (aw_idx)
      `NGP_IDX_PORT_A,
      `NGP_IDX_PORT_B,
      `NGP_IDX_PORT_C,
      `NGP_IDX_OUT_LATCH,
      `NGP_IDX_CONFIG,
      `NGP_IDX_STATUS,
      `NGP_IDX_IN_LEVEL: wr_hit = 1'b1;
      default: wr_hit = ctrl_range;
    endcase
  end

  // ============================================================
  // Latches and shared configuration
  // Stores happen on the edge that raises the response
  // Config has no read path, so software must keep a copy
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_only_port_latch <= `NGP_LATCH_RST; // [R2]
      bidir_port_a_latch <= `NGP_LATCH_RST; // [R19]
      bidir_port_b_latch <= `NGP_LATCH_RST; // [R19]
      bidir_port_c_latch <= `NGP_LATCH_RST; // [R19]
      shared_port_config <= `NGP_CFG_RST; // [R6] [R7] [R8]
    end else if (wr_en) begin
      case (aw_idx)
        `NGP_IDX_OUT_LATCH: output_only_port_latch <= w_data; // [R2]
        `NGP_IDX_PORT_A: bidir_port_a_latch <= w_data;
        `NGP_IDX_PORT_B: bidir_port_b_latch <= w_data; // [R18]
        `NGP_IDX_PORT_C: bidir_port_c_latch <= w_data; // [R18]
        // No read-back exists, so read-modify-write would corrupt it
        `NGP_IDX_CONFIG: shared_port_config <= w_data; // [R5]
        default: shared_port_config <= shared_port_config;
      endcase
    end
  end

  // ============================================================
  // Per-pin control registers and pin drivers
  // Control nibble n: irq enable, irq clock, direction, type
  // Irq bits are only exported; pin interrupt detection lives elsewhere
  genvar n;
  generate
    for (n = 0; n < 12; n = n + 1) begin : g_pin
      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_ctrl[4*n+3:4*n] <= `NGP_CTRL_RST; // [R20]
        end else if (wr_en & ctrl_range & ctrl_onehot[n]) begin
          pin_ctrl[4*n+3:4*n] <= w_data; // [R15] [R20]
        end
      end
      assign dir_bits[n] = pin_ctrl[4*n+`NGP_CTRL_DIR];
      assign type_bits[n] = pin_ctrl[4*n+`NGP_CTRL_TYPE];

      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          bidir_pin_out[n] <= 1'b0;
          bidir_pin_oe_n[n] <= 1'b1;
          bidir_pull_en[n] <= 1'b0;
          pin_irq_enable_bit[n] <= 1'b0;
          pin_irq_sample_clock_bit[n] <= 1'b0;
        end else begin
          // Pins follow the latch one edge after it is written
          bidir_pin_out[n] <= bidir_latch_all[n]; // [R3] [R16]
          if (!dir_bits[n]) begin
            bidir_pin_oe_n[n] <= 1'b1;
          end else if (type_bits[n]) begin
            // Open drain: drive only a low level
            bidir_pin_oe_n[n] <= bidir_latch_all[n]; // [R15] [R16]
          end else begin
            bidir_pin_oe_n[n] <= 1'b0; // [R16]
          end
          bidir_pull_en[n] <= ~dir_bits[n] & ~type_bits[n]; // [R6] [R15]
          pin_irq_enable_bit[n] <= pin_ctrl[4*n+`NGP_CTRL_IRQ_EN]; // [R20]
          pin_irq_sample_clock_bit[n] <= pin_ctrl[4*n+`NGP_CTRL_IRQ_CLK];
        end
      end
    end
  endgenerate

  // ============================================================
  // Output-only and input-only pin controls
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_only_data <= 4'h0;
      out_only_oe_n <= 4'h0;
      in_only_term_en <= 1'b1;
      pull_polarity_select <= 1'b0;
      ext1_vector <= `NGP_EXT1_VECTOR;
    end else begin
      out_only_data <= output_only_port_latch; // [R2] [R3]
      // One bit steers all four pins together
      // Open drain releases the pin for a one and drives a zero
      if (shared_port_config[`NGP_CFG_OUT_DRIVE]) begin
        out_only_oe_n <= output_only_port_latch; // [R7]
      end else begin
        out_only_oe_n <= 4'h0; // [R7]
      end
      in_only_term_en <= ~shared_port_config[`NGP_CFG_IN_TERM]; // [R8]
      pull_polarity_select <= shared_port_config[`NGP_CFG_PULL_SEL]; // [R6]
      ext1_vector <= `NGP_EXT1_VECTOR; // [R14]
    end
  end

  // ============================================================
  // External interrupt 1 level-change detection
  reg tb_prev;
  reg samp_level;
  reg samp_valid;
  wire tb_fall;
  wire comb_level;
  wire ext1_set;
  wire ext1_clr;

  // First falling edge after reset only primes the sample
  // Changing the pull select between samples may raise one extra flag
  assign tb_fall = tb_prev & ~tb_64hz; // [R9]
  // Pull-down idles low: OR sees first rise and last fall
  // Pull-up idles high: AND sees first fall and last rise
  assign comb_level = shared_port_config[`NGP_CFG_PULL_SEL] ? (|in_sync) : // [R12]
                      (&in_sync); // [R13]
  assign ext1_set = tb_fall & samp_valid & (comb_level != samp_level); // [R10] [R11] [R21]
  // Writing one to the status bit clears the flag
  assign ext1_clr = wr_en & (aw_idx == `NGP_IDX_STATUS) & w_data[`NGP_STAT_EXT1];

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_prev <= 1'b0;
      samp_level <= 1'b0;
      samp_valid <= 1'b0;
      ext1_request_flag <= 1'b0;
    end else begin
      tb_prev <= tb_64hz;
      if (tb_fall) begin
        samp_level <= comb_level; // [R9] [R21]
        samp_valid <= 1'b1;
      end
      // A new event beats a clear in the same cycle
      if (ext1_set) begin
        ext1_request_flag <= 1'b1; // [R11]
      end else if (ext1_clr) begin
        ext1_request_flag <= 1'b0;
      end
    end
  end

  // ============================================================
  // AXI4-Lite read channel
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  wire [5:0] rd_idx;
  wire [11:0] bidir_read;

  // Read data is frozen at acceptance; later pin moves wait for the next read
  // Control registers read as zero with OKAY, unmapped gives SLVERR
  // Arready returns once the previous data has been taken
  assign rd_idx = s_axi_araddr[7:2];
  assign bidir_read = (dir_bits & bidir_latch_all) | (~dir_bits & bidir_sync); // [R17]

  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `NGP_RESP_OKAY;
    case (rd_idx)
      `NGP_IDX_IN_LEVEL: next_rdata[3:0] = in_sync; // [R1] [R4]
      `NGP_IDX_PORT_A: next_rdata[3:0] = bidir_read[3:0]; // [R17]
      `NGP_IDX_PORT_B: next_rdata[3:0] = bidir_read[7:4]; // [R18]
      `NGP_IDX_PORT_C: next_rdata[3:0] = bidir_read[11:8]; // [R18]
      `NGP_IDX_OUT_LATCH: next_rdata[3:0] = output_only_port_latch; // [R2]
      `NGP_IDX_CONFIG: next_rdata[3:0] = 4'h0;
      `NGP_IDX_STATUS: next_rdata[`NGP_STAT_EXT1] = ext1_request_flag;
      default: begin
        if (!((rd_idx >= `NGP_IDX_CTRL0) &&
              (rd_idx < (`NGP_IDX_CTRL0 + `NGP_CTRL_COUNT)))) begin
          next_rresp = `NGP_RESP_SLVERR;
        end
      end
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `NGP_RESP_OKAY;
    end else begin
      if (s_axi_arready & s_axi_arvalid) begin
        // Port value is captured at the acceptance edge
        s_axi_rdata <= next_rdata; // [R4]
        s_axi_rresp <= next_rresp;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end else begin
        if (s_axi_rvalid & s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
        if (~s_axi_rvalid) begin
          s_axi_arready <= 1'b1;
        end
      end
    end
  end

endmodule // ngp_gpio

// ---- hdl/ngp_regs.vh ----
`ifndef NGP_REGS_VH
`define NGP_REGS_VH
// ============================================================
// Register indices (byte address = index * 4)
`define NGP_IDX_IN_LEVEL 6'h08
`define NGP_IDX_PORT_B 6'h01
`define NGP_IDX_PORT_C 6'h02
`define NGP_IDX_PORT_A 6'h03
`define NGP_IDX_OUT_LATCH 6'h04
`define NGP_IDX_CONFIG 6'h05
`define NGP_IDX_CTRL0 6'h10
`define NGP_CTRL_COUNT 6'h0C
`define NGP_IDX_STATUS 6'h20
// ============================================================
// Field positions
`define NGP_CFG_PULL_SEL 2
`define NGP_CFG_OUT_DRIVE 1
`define NGP_CFG_IN_TERM 0
`define NGP_CTRL_IRQ_EN 3
`define NGP_CTRL_IRQ_CLK 2
`define NGP_CTRL_DIR 1
`define NGP_CTRL_TYPE 0
`define NGP_STAT_EXT1 0
// ============================================================
// Reset values and constants
`define NGP_LATCH_RST 4'h0
`define NGP_CFG_RST 4'h0
`define NGP_CTRL_RST 4'h0
`define NGP_EXT1_VECTOR 12'h032
`define NGP_RESP_OKAY 2'h0
`define NGP_RESP_SLVERR 2'h2
`endif

// ---- tb/ngp_gpio_props.sv ----
// ============================================================
// Port-level checks on the gpio block
module ngp_props (
  input wire sys_clk,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire tb_64hz,
  input wire [3:0] out_only_data,
  input wire [3:0] out_only_oe_n,
  input wire [11:0] bidir_pin_oe_n,
  input wire [11:0] bidir_pull_en,
  input wire ext1_request_flag,
  input wire [11:0] ext1_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("no read data");
  a_vector_fixed: assert property (ext1_vector == 12'h032) else $error("bad vector");
  a_out_mode: assert property (out_only_oe_n == 4'h0 || out_only_oe_n == out_only_data)
    else $error("output drive mode wrong");
  a_pull_drive: assert property ((bidir_pull_en & ~bidir_pin_oe_n) == 12'h000)
    else $error("pull on a driven pin");
  a_rdata_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
    else $error("read data upper bits set");
  // Pins may only move after a write response was up
  a_out_cause: assert property (!$stable(out_only_data) |-> $past(s_axi_bvalid))
    else $error("output pins moved without write");
  a_flag_cause: assert property ($rose(ext1_request_flag) |-> !$past(tb_64hz)
    && $past(tb_64hz, 2)) else $error("flag set off time base fall");
  a_flag_clear: assert property ($fell(ext1_request_flag) |-> s_axi_bvalid)
    else $error("flag cleared without write");
endmodule // ngp_props

bind ngp_gpio ngp_props u_props (.*);

// ---- tb/ngp_ext_model.sv ----
// ============================================================
// External equipment on the bidirectional pins
module ngp_ext_model (
  input wire [11:0] pin_out,
  input wire [11:0] oe_n,
  input wire [11:0] pull_en,
  input wire pull_sel,
  input wire [11:0] drv_en,
  input wire [11:0] drv,
  output wire [11:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins without pull show the inverse so a stale value cannot pass
  assign pin_in = (~oe_n & pin_out) | (oe_n & drv_en & drv)
    | (oe_n & ~drv_en & pull_en & {12{~pull_sel}})
    | (oe_n & ~drv_en & ~pull_en & ~pin_out);
endmodule // ngp_ext_model

// ---- tb/ngp_gpio_tb.sv ----
module ngp_gpio_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0, tb_64hz = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hF, in_only_pin = 0, v;
  reg [11:0] ext_drv = 0, ext_en = 12'hFFF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire in_only_term_en, pull_polarity_select, ext1_request_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] out_only_data, out_only_oe_n;
  wire [11:0] bidir_pin_in, bidir_pin_out, bidir_pin_oe_n, bidir_pull_en;
  wire [11:0] pin_irq_enable_bit, pin_irq_sample_clock_bit, ext1_vector;
  integer mismatches = 0, compares = 0, seed = 32'h4380D88C, n, i;
  reg [33:0] exp_r[$];
  reg [1:0] exp_b[$];

  always #2.5 sys_clk = ~sys_clk;
  ngp_gpio dut (.*);
  ngp_ext_model ext (.pin_out(bidir_pin_out), .oe_n(bidir_pin_oe_n), .pull_en(bidir_pull_en),
    .pull_sel(pull_polarity_select), .drv_en(ext_en), .drv(ext_drv), .pin_in(bidir_pin_in));

  // ============================================================
  // Checking and bus tasks
  task test_done;
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input [33:0] e, input [33:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  task wr(input [7:0] a, input [3:0] d, input [1:0] r);
    reg aw, w, b;
    exp_b.push_back(r);
    // One edge between calls so a strobe is never lowered and raised in one step
    @(posedge sys_clk);
    aw = 1;
    w = 1;
    b = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; aw | w | b; n++) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
      if (b && s_axi_bvalid) begin
        b = 0;
        s_axi_bready <= 0;
      end
      if (n > 40) begin
        mismatches++;
        test_done;
      end
    end
  endtask
  task rd(input [7:0] a, input [1:0] r, input [3:0] d);
    reg ar, rr;
    exp_r.push_back({r, 28'h0, d});
    @(posedge sys_clk);
    ar = 1;
    rr = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; ar | rr; n++) begin
      @(posedge sys_clk);
      if (ar && s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 0;
      end
      if (rr && s_axi_rvalid) begin
        rr = 0;
        s_axi_rready <= 0;
      end
      if (n > 40) begin
        mismatches++;
        test_done;
      end
    end
  endtask
  task fall;
    tb_64hz <= 1;
    tick(3);
    tb_64hz <= 0;
    tick(3);
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", exp_b.pop_front(), s_axi_bresp);
  end

  // ============================================================
  // Main sequence
  initial begin
    tick(4);
    sys_rst <= 0;
    tick(2);
    chk("out rst", 0, out_only_data);
    chk("bidir rst", 0, bidir_pin_out);
    rd(8'h14, 0, 0);
    rd(8'hFC, 2, 0);
    wr(8'hFC, 4'h1, 2);
    repeat (4) begin
      v = $random(seed);
      wr(8'h10, v, 0);
      tick(2);
      chk("out pins", v, out_only_data);
      rd(8'h10, 0, v);
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h14, i[3:0], 0);
      tick(2);
      chk("pull sel", i[2], pull_polarity_select);
      chk("term", !i[0], in_only_term_en);
      chk("out oe", i[1] ? v : 4'h0, out_only_oe_n);
    end
    repeat (3) begin
      in_only_pin <= $random(seed);
      tick(4);
      rd(8'h20, 0, in_only_pin);
    end
    // A0 push-pull out with irq bits, A1 open drain, A2 resistor in, A3 high-Z in
    wr(8'h40, 4'hE, 0);
    wr(8'h44, 4'h3, 0);
    wr(8'h4C, 4'h1, 0);
    v = $random(seed);
    wr(8'h0C, v, 0);
    ext_drv <= $random(seed);
    ext_en <= 12'hFFB;
    tick(4);
    chk("irq bits", 2'b11, {pin_irq_enable_bit[0], pin_irq_sample_clock_bit[0]});
    chk("a oe", {3'b111, v[1], 1'b0}, {bidir_pull_en[2], bidir_pin_oe_n[3:0]});
    chk("a out", v[1:0], bidir_pin_out[1:0]);
    rd(8'h0C, 0, {ext_drv[3], 1'b0, v[1:0]});
    wr(8'h04, v, 0);
    wr(8'h08, ~v, 0);
    tick(2);
    chk("bc latch", {~v, v}, bidir_pin_out[11:4]);
    rd(8'h04, 0, ext_drv[7:4]);
    for (i = 0; i < 2; i++) begin
      wr(8'h14, {1'b0, i[0], 2'b00}, 0);
      in_only_pin <= i ? 4'h0 : 4'hF;
      tick(4);
      fall;
      fall;
      wr(8'h80, 4'h1, 0);
      fall;
      chk("flag quiet", 0, ext1_request_flag);
      in_only_pin <= i ? 4'h1 : 4'hE;
      tick(4);
      fall;
      chk("flag set", 1, ext1_request_flag);
    end
    test_done;
  end
endmodule // ngp_gpio_tb
